// *** gwg_cfg.svh ***
`ifndef GWG_CFG_SVH
`define GWG_CFG_SVH
// command codes seen on the management bus
`define GWG_CMD_KEY    8'hFA
`define GWG_CMD_MASK   8'hFB
`define GWG_CMD_WP     8'h10
`define GWG_CMD_SAVE   8'h15
`define GWG_CMD_VMODE  8'h20
`define GWG_CMD_VCMD   8'h21
`define GWG_CMD_VTRIM  8'h22
`define GWG_CMD_VMAX   8'h24
`define GWG_CMD_VSCALE 8'h29
`define GWG_CMD_VMIN   8'h2B
`define GWG_CMD_ICALG  8'h38
`define GWG_CMD_ICALO  8'h39
`define GWG_CMD_OVFL   8'h40
`define GWG_CMD_OVFR   8'h41
`define GWG_CMD_UVFL   8'h44
`define GWG_CMD_UVFR   8'h45
// lock mask field positions
`define GWG_B_SELF     15
`define GWG_B_WP       14
`define GWG_B_TRIM     13
`define GWG_B_SETPT    12
`define GWG_B_FLT      11
`define GWG_B_KEYL     1
`define GWG_B_SAVE     0
// key status words and constants
`define GWG_ST_OPEN    16'h0000
`define GWG_ST_FAIL0   16'h000F
`define GWG_ST_FAIL1   16'h001F
`define GWG_ST_FAIL2   16'h002F
`define GWG_ST_BARRED  16'h00FF
`define GWG_KEY_ZERO   16'h0000
`define GWG_FAIL_MAX   2'h3
`define GWG_MASK_RST   16'hFFFF
`define GWG_KEY_RST    16'h0000
`endif

// *** gwg_cmd_class.sv ***
`timescale 1ns/1ps
`include "gwg_cfg.svh"
module gwg_cmd_class (
    input  wire logic [7:0]       code,
    output gwg_pkg::gwg_grp_t     grp
);
    import gwg_pkg::*;
    // map a command code onto the group that guards it
    always_comb
    begin
        case (code)
            `GWG_CMD_KEY:  grp = GRP_KEY;
            `GWG_CMD_MASK: grp = GRP_MASK;
            `GWG_CMD_WP:   grp = GRP_WP;
            `GWG_CMD_SAVE: grp = GRP_SAVE;
            `GWG_CMD_VTRIM, `GWG_CMD_VSCALE,
            `GWG_CMD_ICALG, `GWG_CMD_ICALO: grp = GRP_TRIM;
            `GWG_CMD_VMODE, `GWG_CMD_VCMD:  grp = GRP_SETPT;
            `GWG_CMD_VMAX, `GWG_CMD_VMIN, `GWG_CMD_OVFL,
            `GWG_CMD_OVFR, `GWG_CMD_UVFL, `GWG_CMD_UVFR: grp = GRP_FLT;
            default:       grp = GRP_OTHER;
        endcase
    end
endmodule : gwg_cmd_class

// *** gwg_host_model.sv ***
`timescale 1ns/1ps
module gwg_host_model (
    input  wire logic        clk,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_wr_ok,
    input  wire logic        rsp_wr_rej,
    input  wire logic [15:0] rsp_rdata,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata
);
    logic [1:0]  last_resp;
    logic [15:0] last_rdata;
    logic        hung;
    // bus idle from time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
        hung      = 1'b0;
    end
    // one word per call, held across the taking edge
    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [15:0] d);
        int n;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code  = c;
        cmd_wdata = d;
        @(negedge clk);
        // released lines show the inverse, never a stale copy
        cmd_valid = 1'b0;
        cmd_write = ~w;
        cmd_code  = ~c;
        cmd_wdata = ~d;
        hung = 1'b1;
        for (n = 0; n < 4 && hung; n++)
        begin
            if (rsp_valid === 1'b1)
            begin
                last_resp  = {rsp_wr_ok, rsp_wr_rej};
                last_rdata = rsp_rdata;
                hung       = 1'b0;
            end
            else
                @(negedge clk);
        end
    endtask : xfer
endmodule : gwg_host_model

// *** gwg_key_if.sv ***
`timescale 1ns/1ps
interface gwg_key_if;
    import gwg_pkg::*;
    logic        boot;
    logic [15:0] boot_key;
    logic        try_wr;
    logic [15:0] wdata;
    logic        take;
    gwg_kst_t    state;
    logic [15:0] status;
    modport ctl (output boot, boot_key, try_wr, wdata,
                 input take, state, status);
    modport key (input boot, boot_key, try_wr, wdata,
                 output take, state, status);
endinterface : gwg_key_if

// *** gwg_key_unit.sv ***
`timescale 1ns/1ps
`include "gwg_cfg.svh"
module gwg_key_unit (
    input  wire logic clk,
    input  wire logic rst,
    gwg_key_if.key    kif
);
    import gwg_pkg::*;
    logic [15:0] key_q;
    gwg_kst_t    st_q;
    logic [1:0]  fail_q;
    logic        zero_key;
    logic        match;
    assign zero_key = (key_q == `GWG_KEY_ZERO);
    assign match    = (kif.wdata == key_q);
    // accept: replace a zero key, or a matching word
    always_comb
    begin
        kif.take = 1'b0;
        if (kif.try_wr && !kif.boot)
        begin
            case (st_q)
                KST_OPEN:   kif.take = zero_key || match;
                KST_SEALED: kif.take = match;
                default:    kif.take = 1'b0;
            endcase
        end
    end
    // active key, reloaded at boot; replaced only while zero
    always_ff @(posedge clk)
    begin
        if (rst)
            key_q <= `GWG_KEY_RST;
        else if (kif.boot)
            key_q <= kif.boot_key;
        else if (kif.try_wr && st_q == KST_OPEN && zero_key)
            key_q <= kif.wdata;
    end
    // lock state; only rst leaves the barred state
    always_ff @(posedge clk)
    begin
        if (rst)
            st_q <= KST_SEALED;
        else if (kif.boot && st_q != KST_BARRED)
            st_q <= (kif.boot_key == `GWG_KEY_ZERO) ? KST_OPEN
                                                    : KST_SEALED;
        else if (!kif.boot && kif.try_wr && st_q != KST_BARRED
                 && !zero_key)
        begin
            if (match)
                st_q <= KST_OPEN;
            else if (fail_q == `GWG_FAIL_MAX - 2'h1)
                st_q <= KST_BARRED;
        end
    end
    // mismatch count, cleared by a matching word
    always_ff @(posedge clk)
    begin
        if (rst)
            fail_q <= 2'h0;
        else if (!kif.boot && kif.try_wr && !zero_key)
        begin
            if (match && st_q != KST_BARRED)
                fail_q <= 2'h0;
            else if (fail_q != `GWG_FAIL_MAX)
                fail_q <= fail_q + 2'h1;
        end
    end
    // status word never exposes the key itself
    always_comb
    begin
        case (st_q)
            KST_OPEN:   kif.status = `GWG_ST_OPEN;
            KST_BARRED: kif.status = `GWG_ST_BARRED;
            default:
            begin
                case (fail_q)
                    2'h0:    kif.status = `GWG_ST_FAIL0;
                    2'h1:    kif.status = `GWG_ST_FAIL1;
                    2'h2:    kif.status = `GWG_ST_FAIL2;
                    default: kif.status = `GWG_ST_BARRED;
                endcase
            end
        endcase
    end
    assign kif.state = st_q;
endmodule : gwg_key_unit

// *** gwg_pkg.sv ***
package gwg_pkg;
    // command group that a code belongs to
    typedef enum logic [2:0] {
        GRP_OTHER, GRP_KEY, GRP_MASK, GRP_WP,
        GRP_TRIM, GRP_SETPT, GRP_FLT, GRP_SAVE
    } gwg_grp_t;
    // unlock key state
    typedef enum logic [1:0] {KST_OPEN, KST_SEALED, KST_BARRED} gwg_kst_t;
endpackage : gwg_pkg

// *** gwg_write_guard.sv ***
// Operation
// - 16-bit unlock key, reloaded at boot
// - zero key allows save, writes replace key
// - nonzero boot key blocks mask and save
// - matching key word unlocks protected writes
// - three mismatches without match cause lockout
// - lockout rejects key writes until power-on
// - key read returns status, never key
// - status words 0000 000F 001F 002F 00FF
// - 16-bit group lock mask at FBh
// - bit 15 freezes mask and key
// - bit 15 clear: key and bit 1 rule
// - bit 14 freezes standard write protect
// - bit 13 freezes trim and calibration
// - bit 12 freezes output setpoint commands
// - bit 11 freezes output limits and faults
// - clear group bit defers to standard protect, except bits 15, 14 and 1 (mask, write protect and key ignore it)
// - bit 1 freezes the unlock key
// - bit 0 freezes save command
`timescale 1ns/1ps
`include "gwg_cfg.svh"
module gwg_write_guard (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        boot_load,
    input  wire logic [15:0] nvm_key,
    input  wire logic [15:0] nvm_mask,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        std_wp_block,
    output logic             rsp_valid,
    output logic             rsp_wr_ok,
    output logic             rsp_wr_rej,
    output logic [15:0]      rsp_rdata,
    output logic [15:0]      group_write_lock_mask,
    output logic             key_open,
    output logic             key_barred,
    output logic             save_allowed
);
    import gwg_pkg::*;

    gwg_key_if          kif ();
    gwg_pkg::gwg_grp_t  grp;
    logic [15:0]        mask_q;
    logic               rsp_valid_q;
    logic               rsp_wr_ok_q;
    logic               rsp_wr_rej_q;
    logic [15:0]        rsp_rdata_q;
    logic               key_open_q;
    logic               key_barred_q;
    logic               save_allowed_q;
    logic               wr_req;
    logic               rd_req;
    logic               opened;
    logic               blocked;
    logic               allow;

    gwg_cmd_class u_class (
        .code (cmd_code),
        .grp  (grp)
    );

    gwg_key_unit u_key (
        .clk (clk),
        .rst (rst),
        .kif (kif)
    );

    // requests from the bus controller share this clock
    assign wr_req = cmd_valid && cmd_write && !boot_load;
    assign rd_req = cmd_valid && !cmd_write;
    assign opened = (kif.state == KST_OPEN);

    // per-group protection decision
    always_comb
    begin
        case (grp)
            GRP_KEY:
                blocked = mask_q[`GWG_B_SELF]
                       || mask_q[`GWG_B_KEYL];
            GRP_MASK:
                blocked = mask_q[`GWG_B_SELF] || !opened;
            GRP_WP:
                blocked = mask_q[`GWG_B_WP];
            GRP_TRIM:
                blocked = mask_q[`GWG_B_TRIM] || std_wp_block;
            GRP_SETPT:
                blocked = mask_q[`GWG_B_SETPT] || std_wp_block;
            GRP_FLT:
                blocked = mask_q[`GWG_B_FLT] || std_wp_block;
            GRP_SAVE:
                blocked = mask_q[`GWG_B_SAVE] || !opened
                       || std_wp_block;
            default:
                blocked = std_wp_block;
        endcase
    end

    // a key write also has to pass the key unit's own check
    always_comb
    begin
        if (grp == GRP_KEY)
            allow = !blocked && kif.take;
        else
            allow = !blocked;
    end

    // hand key traffic to the key unit only when not frozen
    assign kif.boot     = boot_load;
    assign kif.boot_key = nvm_key;
    assign kif.wdata    = cmd_wdata;
    assign kif.try_wr   = wr_req && grp == GRP_KEY && !blocked;

    // lock mask: boot copy, then guarded word writes
    always_ff @(posedge clk)
    begin
        if (rst)
            mask_q <= `GWG_MASK_RST;
        else if (boot_load)
            mask_q <= nvm_mask;
        else if (wr_req && grp == GRP_MASK && allow)
            mask_q <= cmd_wdata;
    end

    // one answer per request, one cycle later
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rsp_valid_q  <= 1'b0;
            rsp_wr_ok_q  <= 1'b0;
            rsp_wr_rej_q <= 1'b0;
        end
        else
        begin
            rsp_valid_q  <= cmd_valid;
            rsp_wr_ok_q  <= wr_req && allow;
            // a write in a boot cycle is refused, never left unanswered
            rsp_wr_rej_q <= cmd_valid && cmd_write
                            && !(wr_req && allow);
        end
    end

    // read data; zero for codes this block does not own
    always_ff @(posedge clk)
    begin
        if (rst)
            rsp_rdata_q <= 16'h0000;
        else if (rd_req && grp == GRP_KEY)
            rsp_rdata_q <= kif.status;
        else if (rd_req && grp == GRP_MASK)
            rsp_rdata_q <= mask_q;
        else
            rsp_rdata_q <= 16'h0000;
    end

    // status flags lag the key unit by one cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            key_open_q     <= 1'b0;
            key_barred_q   <= 1'b0;
            save_allowed_q <= 1'b0;
        end
        else
        begin
            key_open_q     <= opened;
            key_barred_q   <= (kif.state == KST_BARRED);
            save_allowed_q <= opened && !mask_q[`GWG_B_SAVE];
        end
    end

    assign rsp_valid             = rsp_valid_q;
    assign rsp_wr_ok             = rsp_wr_ok_q;
    assign rsp_wr_rej            = rsp_wr_rej_q;
    assign rsp_rdata             = rsp_rdata_q;
    assign group_write_lock_mask = mask_q;
    assign key_open              = key_open_q;
    assign key_barred            = key_barred_q;
    assign save_allowed          = save_allowed_q;

    // checks on the guard's own decisions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_mask_wr;
        wr_req && grp == GRP_MASK;
    endsequence

    sequence s_key_wr;
        wr_req && grp == GRP_KEY;
    endsequence

    sequence s_last_miss;
        s_key_wr ##0 !kif.take ##0 kif.status == `GWG_ST_FAIL2
            ##0 !blocked;
    endsequence

    property p_mask_sealed;
        s_mask_wr ##0 !opened |=> rsp_wr_rej && $stable(mask_q);
    endproperty
    a_mask_sealed: assert property (p_mask_sealed)
        else $error("mask changed while key sealed");

    property p_self_lock;
        s_mask_wr ##0 mask_q[`GWG_B_SELF] |=> rsp_wr_rej
            && $stable(mask_q);
    endproperty
    a_self_lock: assert property (p_self_lock)
        else $error("frozen mask accepted a write");

    property p_key_frozen;
        s_key_wr ##0 (mask_q[`GWG_B_KEYL] || mask_q[`GWG_B_SELF])
            |=> rsp_wr_rej && !rsp_wr_ok;
    endproperty
    a_key_frozen: assert property (p_key_frozen)
        else $error("frozen key accepted a write");

    property p_wp_bit;
        wr_req && grp == GRP_WP |=> rsp_wr_ok == !$past(mask_q[14]);
    endproperty
    a_wp_bit: assert property (p_wp_bit)
        else $error("write protect gating wrong");

    property p_trim_bit;
        wr_req && grp == GRP_TRIM && (mask_q[13] || std_wp_block)
            |=> rsp_wr_rej;
    endproperty
    a_trim_bit: assert property (p_trim_bit)
        else $error("trim group write not refused");

    property p_setpt_open;
        wr_req && grp == GRP_SETPT && !mask_q[12] && !std_wp_block
            |=> rsp_wr_ok;
    endproperty
    a_setpt_open: assert property (p_setpt_open)
        else $error("setpoint write refused without cause");

    property p_flt_bit;
        wr_req && grp == GRP_FLT && mask_q[11] |=> rsp_wr_rej;
    endproperty
    a_flt_bit: assert property (p_flt_bit)
        else $error("fault limit write not refused");

    property p_save_gate;
        wr_req && grp == GRP_SAVE |=>
            rsp_wr_ok == ($past(opened) && !$past(mask_q[0])
                          && !$past(std_wp_block));
    endproperty
    a_save_gate: assert property (p_save_gate)
        else $error("save command gating wrong");

    property p_status_open;
        rd_req && grp == GRP_KEY && opened |=> rsp_rdata == 16'h0000
            ##0 rsp_valid;
    endproperty
    a_status_open: assert property (p_status_open)
        else $error("open key status word wrong");

    property p_third_miss;
        s_last_miss |=> kif.state == KST_BARRED ##1 key_barred;
    endproperty
    a_third_miss: assert property (p_third_miss)
        else $error("third mismatch did not lock out");

    property p_barred_holds;
        kif.state == KST_BARRED |=> kif.state == KST_BARRED
            && !kif.take;
    endproperty
    a_barred_holds: assert property (p_barred_holds)
        else $error("lockout left without reset");

    property p_boot_mask;
        boot_load |=> mask_q == $past(nvm_mask);
    endproperty
    a_boot_mask: assert property (p_boot_mask)
        else $error("mask not reloaded at boot");

    // answer framing: every request gets an answer, every write exactly one verdict
    sequence s_wr_any;
        cmd_valid && cmd_write;
    endsequence

    property p_answer;
        cmd_valid |=> rsp_valid;
    endproperty
    a_answer: assert property (p_answer)
        else $error("request left without an answer");

    property p_idle;
        !cmd_valid |=> !rsp_valid && !rsp_wr_ok && !rsp_wr_rej
            && rsp_rdata == 16'h0000;
    endproperty
    a_idle: assert property (p_idle)
        else $error("answer without a request");

    property p_wr_verdict;
        s_wr_any |=> rsp_wr_ok != rsp_wr_rej;
    endproperty
    a_wr_verdict: assert property (p_wr_verdict)
        else $error("write answer not exactly one verdict");

    property p_mask_read;
        rd_req && grp == GRP_MASK |=> rsp_rdata == $past(mask_q);
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask read returned wrong word");

    property p_status_sealed;
        rd_req && grp == GRP_KEY && !opened
            |=> rsp_rdata[15:8] == 8'h00 && rsp_rdata[3:0] == 4'hF;
    endproperty
    a_status_sealed: assert property (p_status_sealed)
        else $error("locked key status word wrong");

    property p_trim_open;
        wr_req && grp == GRP_TRIM && !mask_q[`GWG_B_TRIM]
            && !std_wp_block |=> rsp_wr_ok;
    endproperty
    a_trim_open: assert property (p_trim_open)
        else $error("trim write refused without cause");

    property p_flt_open;
        wr_req && grp == GRP_FLT && !mask_q[`GWG_B_FLT]
            && !std_wp_block |=> rsp_wr_ok;
    endproperty
    a_flt_open: assert property (p_flt_open)
        else $error("fault limit write refused without cause");

    property p_other_grp;
        wr_req && grp == GRP_OTHER
            |=> rsp_wr_ok == !$past(std_wp_block);
    endproperty
    a_other_grp: assert property (p_other_grp)
        else $error("unguarded code gated wrongly");

    // boot decides sealed or open unless locked out
    property p_boot_key;
        boot_load && kif.state != KST_BARRED |=>
            opened == ($past(nvm_key) == `GWG_KEY_ZERO);
    endproperty
    a_boot_key: assert property (p_boot_key)
        else $error("boot key state wrong");

    property p_match_opens;
        s_key_wr ##0 !blocked ##0 kif.take |=> opened && rsp_wr_ok;
    endproperty
    a_match_opens: assert property (p_match_opens)
        else $error("accepted key word did not open");
endmodule : gwg_write_guard

// *** testbench.sv ***
`timescale 1ns/1ps
`include "gwg_cfg.svh"
module testbench;
    logic        clk;
    logic        rst;
    logic        boot_load;
    logic [15:0] nvm_key;
    logic [15:0] nvm_mask;
    logic        std_wp_block;
    logic        cmd_valid;
    logic        cmd_write;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata;
    logic        rsp_valid;
    logic        rsp_wr_ok;
    logic        rsp_wr_rej;
    logic [15:0] rsp_rdata;
    logic [15:0] mask;
    logic        key_open;
    logic        key_barred;
    logic        save_allowed;
    int          miscompares = 0;
    int          total_checks = 0;

    gwg_write_guard dut_u (
        .clk                   (clk),
        .rst                   (rst),
        .boot_load             (boot_load),
        .nvm_key               (nvm_key),
        .nvm_mask              (nvm_mask),
        .cmd_valid             (cmd_valid),
        .cmd_write             (cmd_write),
        .cmd_code              (cmd_code),
        .cmd_wdata             (cmd_wdata),
        .std_wp_block          (std_wp_block),
        .rsp_valid             (rsp_valid),
        .rsp_wr_ok             (rsp_wr_ok),
        .rsp_wr_rej            (rsp_wr_rej),
        .rsp_rdata             (rsp_rdata),
        .group_write_lock_mask (mask),
        .key_open              (key_open),
        .key_barred            (key_barred),
        .save_allowed          (save_allowed)
    );

    gwg_host_model host_u (
        .clk        (clk),
        .rsp_valid  (rsp_valid),
        .rsp_wr_ok  (rsp_wr_ok),
        .rsp_wr_rej (rsp_wr_rej),
        .rsp_rdata  (rsp_rdata),
        .cmd_valid  (cmd_valid),
        .cmd_write  (cmd_write),
        .cmd_code   (cmd_code),
        .cmd_wdata  (cmd_wdata)
    );

    // free-running 50 MHz clock
    always #10 clk = ~clk;

    task automatic results;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // a missing answer ends the run rather than hanging it
    task automatic go(input logic w, input logic [7:0] c,
                      input logic [15:0] d);
        host_u.xfer(w, c, d);
        if (host_u.hung)
        begin
            miscompares++;
            results();
        end
    endtask : go

    task automatic wr(input logic [7:0] c, input logic [15:0] d,
                      input logic ok);
        go(1'b1, c, d);
        chk({14'h0, host_u.last_resp}, ok ? 16'h0002 : 16'h0001);
    endtask : wr

    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        go(1'b0, c, 16'h0000);
        chk(host_u.last_rdata, exp);
    endtask : rd

    task automatic do_reset;
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
    endtask : do_reset

    // extra cycle since the key flags lag the key state
    task automatic boot(input logic [15:0] k, input logic [15:0] m);
        @(negedge clk);
        boot_load = 1'b1;
        nvm_key   = k;
        nvm_mask  = m;
        @(negedge clk);
        boot_load = 1'b0;
        @(negedge clk);
    endtask : boot

    task automatic t_open;
        boot(`GWG_KEY_ZERO, 16'h0000);
        chk({14'h0, key_open, save_allowed}, 16'h0003);
        rd(`GWG_CMD_KEY, `GWG_ST_OPEN);
        wr(`GWG_CMD_SAVE, 16'h0000, 1'b1);
        wr(`GWG_CMD_KEY, 16'hA5C3, 1'b1);
        rd(`GWG_CMD_KEY, `GWG_ST_OPEN);
        $display("t_open done");
    endtask : t_open

    task automatic t_seal;
        boot(16'hA5C3, 16'h0000);
        chk({14'h0, key_open, save_allowed}, 16'h0000);
        rd(`GWG_CMD_KEY, `GWG_ST_FAIL0);
        wr(`GWG_CMD_MASK, 16'h00F0, 1'b0);
        chk(mask, 16'h0000);
        rd(`GWG_CMD_MASK, 16'h0000);
        wr(`GWG_CMD_SAVE, 16'h0000, 1'b0);
        wr(`GWG_CMD_KEY, 16'hA5C2, 1'b0);
        rd(`GWG_CMD_KEY, `GWG_ST_FAIL1);
        wr(`GWG_CMD_KEY, 16'h0000, 1'b0);
        rd(`GWG_CMD_KEY, `GWG_ST_FAIL2);
        wr(`GWG_CMD_KEY, 16'hA5C3, 1'b1);
        @(negedge clk);
        chk({15'h0, key_open}, 16'h0001);
        rd(`GWG_CMD_KEY, `GWG_ST_OPEN);
        wr(`GWG_CMD_MASK, 16'h0001, 1'b1);
        rd(`GWG_CMD_MASK, 16'h0001);
        wr(`GWG_CMD_SAVE, 16'h0000, 1'b0);
        $display("t_seal done");
    endtask : t_seal

    // a match in between restarts the miss count
    task automatic t_bar;
        boot(16'h1234, 16'h0000);
        wr(`GWG_CMD_KEY, 16'h4321, 1'b0);
        wr(`GWG_CMD_KEY, 16'h4321, 1'b0);
        wr(`GWG_CMD_KEY, 16'h1234, 1'b1);
        wr(`GWG_CMD_KEY, 16'h4321, 1'b0);
        @(negedge clk);
        chk({15'h0, key_barred}, 16'h0000);
        // a boot is no match: the third miss lands while sealed
        boot(16'h1234, 16'h0000);
        wr(`GWG_CMD_KEY, 16'h4321, 1'b0);
        rd(`GWG_CMD_KEY, `GWG_ST_FAIL2);
        wr(`GWG_CMD_KEY, 16'h4321, 1'b0);
        rd(`GWG_CMD_KEY, `GWG_ST_BARRED);
        chk({15'h0, key_barred}, 16'h0001);
        wr(`GWG_CMD_KEY, 16'h1234, 1'b0);
        boot(16'h1234, 16'h0000);
        rd(`GWG_CMD_KEY, `GWG_ST_BARRED);
        do_reset();
        boot(16'h1234, 16'h0000);
        rd(`GWG_CMD_KEY, `GWG_ST_FAIL0);
        $display("t_bar done");
    endtask : t_bar

    task automatic t_groups;
        logic [7:0] codes [13] = '{8'h10, 8'h22, 8'h29, 8'h38, 8'h39,
            8'h20, 8'h21, 8'h24, 8'h2B, 8'h40, 8'h41, 8'h44, 8'h45};
        int bits [13] = '{14, 13, 13, 13, 13, 12, 12, 11, 11, 11, 11,
            11, 11};
        boot(`GWG_KEY_ZERO, 16'h0000);
        foreach (codes[i])
        begin
            wr(`GWG_CMD_MASK, 16'h0001 << bits[i], 1'b1);
            wr(codes[i], 16'h00A5, 1'b0);
            wr(`GWG_CMD_MASK, 16'h0000, 1'b1);
            std_wp_block = 1'b1;
            wr(codes[i], 16'h00A5, bits[i] == 14);
            std_wp_block = 1'b0;
            wr(codes[i], 16'h00A5, 1'b1);
        end
        // a code outside every group only obeys standard protect
        wr(8'h01, 16'h00A5, 1'b1);
        std_wp_block = 1'b1;
        wr(8'h01, 16'h00A5, 1'b0);
        std_wp_block = 1'b0;
        wr(`GWG_CMD_MASK, 16'h0002, 1'b1);
        wr(`GWG_CMD_KEY, 16'h7777, 1'b0);
        wr(`GWG_CMD_MASK, 16'h8000, 1'b1);
        chk(mask, 16'h8000);
        wr(`GWG_CMD_MASK, 16'h0000, 1'b0);
        rd(`GWG_CMD_MASK, 16'h8000);
        wr(`GWG_CMD_KEY, 16'h7777, 1'b0);
        rd(`GWG_CMD_KEY, `GWG_ST_OPEN);
        $display("t_groups done");
    endtask : t_groups

    // inputs settle at time zero, reset held three cycles
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        boot_load = 1'b0;
        nvm_key = 16'h0000;
        nvm_mask = 16'h0000;
        std_wp_block = 1'b0;
        do_reset();
        t_open();
        t_seal();
        t_bar();
        t_groups();
        results();
    end
endmodule : testbench
